// ===== rtl/rtcs_defs.vh
// Purpose: Constants for the real-time counter control and synchroniser block.
// Assumes: Register index times four is the byte address on the APB bus.
// Notes: Every offset lives here, with the control, flag and debug field positions, byte and word reset values and sync counts.
// Operation
// - Counter runs in idle sleep; in standby only with run_in_standby set.
// - Periodic timer keeps running in every sleep mode.
// - Counter and periodic timer advance only on edges of the selected RTC clock.
// - Status shows match, limit, count and control sync pending on bits 3..0.
// - Periodic status bit 0 shows periodic control write still synchronising.
// - Prescaler field bits 6:3 divides the RTC clock by two to its value.
// - Control writes reach counter logic after two RTC edges, flag set meanwhile.
// - Control bit 0 enables the counter.
// - Interrupt enable bit 1 match, bit 0 wrap; request needs enable and flag.
// - Match flag bit 1 sets on count equal match value, write one clears.
// - At the wrap limit the count returns to zero and sets flag bit 0.
// - One shared byte latch, read/write, reset zero, serves all 16-bit registers.
// - Control, status, interrupt enable and flags reset to zero.
// - Shared prescaler stops when both enables are zero, runs otherwise.
// - Clock source 0 internal 32k, 1 divided 1k, 3 external pin, 2 reserved.
// - Periodic field picks 4 up to 32768 cycles; value 0 gives no interrupt.
`ifndef RTCS_DEFS_VH
`define RTCS_DEFS_VH

// ==========================================================================
// Register indices
`define RTCS_IDX_CTRL 8'h00
`define RTCS_IDX_STATUS 8'h01
`define RTCS_IDX_INTEN 8'h02
`define RTCS_IDX_FLAGS 8'h03
`define RTCS_IDX_LATCH 8'h04
`define RTCS_IDX_DBG 8'h05
`define RTCS_IDX_SRCSEL 8'h07
`define RTCS_IDX_CNT 8'h08
`define RTCS_IDX_PER 8'h0a
`define RTCS_IDX_CMP 8'h0c
`define RTCS_IDX_PCTRL 8'h10
`define RTCS_IDX_PSTATUS 8'h11
`define RTCS_IDX_PINTEN 8'h12
`define RTCS_IDX_PFLAGS 8'h13
`define RTCS_IDX_PDBG 8'h15

// ==========================================================================
// Field positions
`define RTCS_CTRL_STBY 7
`define RTCS_DIV_MSB 6
`define RTCS_DIV_LSB 3
`define RTCS_EN_BIT 0
`define RTCS_CMP_BIT 1
`define RTCS_WRAP_BIT 0
`define RTCS_HALTRUN_BIT 0

// ==========================================================================
// Reset values and counts
`define RTCS_RST_BYTE 8'h00
`define RTCS_RST_WORD 16'h0000
`define RTCS_RST_LIMIT 16'hffff
`define RTCS_SYNC_EDGES 2'h2
`define RTCS_SLOTS 5

`endif

// ===== rtl/rtcs_prescaler.v
// Purpose: Shared prescaler counter feeding counter ticks and periodic edges.
// Assumes: RTC edges arrive as one-cycle pulses in the bus clock domain.
// Notes: Counter clears whenever it is stopped, so it restarts from zero.
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_defs.vh"

module rtcs_prescaler (
  input wire clk,             // Bus clock
  input wire rst_n,           // Synchronised reset, active low
  input wire i_rtc_edge,      // RTC clock edge pulse
  input wire i_run,           // Either function enabled
  input wire [3:0] i_div,     // Prescaler exponent
  input wire [3:0] i_period,  // Periodic interval select
  output wire o_tick,         // Prescaled counter tick
  output wire o_pit_rise      // Periodic output rising edge
);
  reg [14:0] cnt_q;
  reg pit_lvl_q;
  wire [14:0] mask;
  wire pit_lvl;

  assign mask = 15'h7fff >> (4'hf - i_div);
  assign o_tick = i_rtc_edge & i_run & ((cnt_q & mask) == mask);
  // Period 2^(n+1) cycles follows prescaler bit n.
  assign pit_lvl = (i_period != 4'h0) && (i_period != 4'hf) && cnt_q[i_period];
  assign o_pit_rise = pit_lvl & ~pit_lvl_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 15'h0000;
      pit_lvl_q <= 1'b0;
    end else begin
      pit_lvl_q <= pit_lvl;
      if (!i_run) begin
        cnt_q <= 15'h0000;
      end else if (i_rtc_edge) begin
        cnt_q <= cnt_q + 15'h0001;
      end
    end
  end
endmodule // rtcs_prescaler

`default_nettype wire

// ===== rtl/rtcs_sync_slot.v
// Purpose: Tracks one register update until it has crossed two RTC edges.
// Assumes: RTC edges arrive as one-cycle pulses in the bus clock domain.
// Notes: A new load restarts the wait.
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_defs.vh"

module rtcs_sync_slot (
  input wire clk,         // Bus clock
  input wire rst_n,       // Synchronised reset, active low
  input wire i_load,      // Register written
  input wire i_rtc_edge,  // RTC clock edge pulse
  output wire o_busy,     // Update pending
  output wire o_apply     // Update takes effect now
);
  reg busy_q;
  reg [1:0] cnt_q;

  // Second RTC edge after the write commits the value.
  assign o_apply = busy_q & i_rtc_edge & (cnt_q == (`RTCS_SYNC_EDGES - 2'h1));
  assign o_busy = busy_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (i_load) begin
      busy_q <= 1'b1;
      cnt_q <= 2'h0;
    end else if (o_apply) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (busy_q && i_rtc_edge) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule // rtcs_sync_slot

`default_nettype wire

// ===== rtl/rtcs_top.v
// Purpose: Real-time counter and periodic timer with APB register access.
// Assumes: RTC source clocks are slow levels sampled by the bus clock.
// Notes: Byte address is register index times four; data in bits 7:0.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_defs.vh"

module rtcs_top (
  input wire I_CLK_SYS,          // Bus clock, 200 MHz
  input wire I_NRST,             // Reset, active low
  input wire I_PSEL,             // APB select
  input wire I_PENABLE,          // APB enable
  input wire I_PWRITE,           // APB direction
  input wire [7:0] I_PADDR,      // APB byte address
  input wire [31:0] I_PWDATA,    // APB write data
  input wire [3:0] I_PSTRB,      // APB byte strobes
  output wire [31:0] O_PRDATA,   // APB read data
  output wire O_PREADY,          // APB ready
  output wire O_PSLVERR,         // APB error
  input wire I_OSC32K,           // Internal 32.768 kHz oscillator level
  input wire I_OSC1K,            // Divided 1.024 kHz level
  input wire I_EXTCLK,           // External clock pin level
  input wire I_SLEEP_STANDBY,    // System in standby sleep
  input wire I_DEBUG_HALT,       // CPU halted by debugger
  output wire O_IRQ              // Interrupt request, active high
);

  // ========================================================================
  // Reset release
  reg [1:0] rst_sync_q;
  wire rst_n;

  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ========================================================================
  // Decoding helpers
  // Returns which 16-bit pair an index falls in: 1 count, 2 limit, 3 match.
  function [1:0] pair_of;
    input [7:0] idx;
    begin
      case ({idx[7:1], 1'b0})
        `RTCS_IDX_CNT: pair_of = 2'h1;
        `RTCS_IDX_PER: pair_of = 2'h2;
        `RTCS_IDX_CMP: pair_of = 2'h3;
        default: pair_of = 2'h0;
      endcase
    end
  endfunction

  function mapped_idx;
    input [7:0] idx;
    begin
      case (idx)
        `RTCS_IDX_CTRL, `RTCS_IDX_STATUS, `RTCS_IDX_INTEN, `RTCS_IDX_FLAGS,
        `RTCS_IDX_LATCH, `RTCS_IDX_DBG, `RTCS_IDX_SRCSEL, `RTCS_IDX_PCTRL,
        `RTCS_IDX_PSTATUS, `RTCS_IDX_PINTEN, `RTCS_IDX_PFLAGS,
        `RTCS_IDX_PDBG: mapped_idx = 1'b1;
        default: mapped_idx = (pair_of(idx) != 2'h0);
      endcase
    end
  endfunction

  // ========================================================================
  // Bus decode
  wire [7:0] idx;
  wire mapped;
  wire [1:0] pair;
  wire access;
  wire wr;
  wire rd;
  wire setup_rd;
  wire [7:0] wdat;

  assign idx = {2'b00, I_PADDR[7:2]};
  assign mapped = mapped_idx(idx);
  assign pair = pair_of(idx);
  assign access = I_PSEL & I_PENABLE;
  assign wr = access & I_PWRITE & I_PSTRB[0] & mapped;
  assign rd = access & ~I_PWRITE & mapped;
  assign setup_rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign wdat = I_PWDATA[7:0];

  // Zero wait states keep every transfer two cycles long.
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access & ~mapped;

  // ========================================================================
  // RTC clock selection and edge detection
  reg [1:0] src_sel_q;
  reg src_lvl;
  reg [1:0] src_sync_q;
  reg src_prev_q;
  wire rtc_edge;

  always @* begin
    case (src_sel_q)
      2'h0: src_lvl = I_OSC32K;
      2'h1: src_lvl = I_OSC1K;
      2'h3: src_lvl = I_EXTCLK;
      default: src_lvl = 1'b0;
    endcase
  end

  // The reserved selection yields no edges, so the counter simply stands still.
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      src_sync_q <= 2'b00;
      src_prev_q <= 1'b0;
    end else begin
      src_sync_q <= {src_sync_q[0], src_lvl};
      src_prev_q <= src_sync_q[1];
    end
  end
  assign rtc_edge = src_sync_q[1] & ~src_prev_q;

  // ========================================================================
  // Bus-side registers
  reg [7:0] ctrl_q;
  reg [1:0] inten_q;
  reg [1:0] flags_q;
  reg [7:0] latch_q;
  reg dbg_q;
  reg [7:0] pctrl_q;
  reg pinten_q;
  reg pflag_q;
  reg pdbg_q;
  reg [15:0] cnt_wr_q;
  reg [15:0] per_wr_q;
  reg [15:0] cmp_wr_q;
  reg [4:0] load;
  wire [4:0] busy;
  wire [4:0] apply;
  wire cmp_ev;
  wire wrap_ev;
  wire pit_ev;
  reg [15:0] cnt_q;
  reg [15:0] per_q;
  reg [15:0] cmp_q;

  // Writes arm the matching sync slot: 0 control, 1 count, 2 limit, 3 match,
  // 4 periodic control.
  always @* begin
    load = 5'h00;
    if (wr) begin
      load[0] = (idx == `RTCS_IDX_CTRL);
      load[1] = (pair == 2'h1) & idx[0];
      load[2] = (pair == 2'h2) & idx[0];
      load[3] = (pair == 2'h3) & idx[0];
      load[4] = (idx == `RTCS_IDX_PCTRL);
    end
  end

  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `RTCS_RST_BYTE;
      inten_q <= 2'h0;
      dbg_q <= 1'b0;
      src_sel_q <= 2'h0;
      pctrl_q <= `RTCS_RST_BYTE;
      pinten_q <= 1'b0;
      pdbg_q <= 1'b0;
      cnt_wr_q <= `RTCS_RST_WORD;
      per_wr_q <= `RTCS_RST_LIMIT;
      cmp_wr_q <= `RTCS_RST_WORD;
    end else if (wr) begin
      case (idx)
        `RTCS_IDX_CTRL: ctrl_q <= {wdat[7:3], 2'b00, wdat[0]};
        `RTCS_IDX_INTEN: inten_q <= wdat[1:0];
        `RTCS_IDX_DBG: dbg_q <= wdat[`RTCS_HALTRUN_BIT];
        `RTCS_IDX_SRCSEL: src_sel_q <= wdat[1:0];
        `RTCS_IDX_PCTRL: pctrl_q <= {1'b0, wdat[6:3], 2'b00, wdat[0]};
        `RTCS_IDX_PINTEN: pinten_q <= wdat[0];
        `RTCS_IDX_PDBG: pdbg_q <= wdat[`RTCS_HALTRUN_BIT];
        `RTCS_IDX_CNT + 8'h01: cnt_wr_q <= {wdat, latch_q};
        `RTCS_IDX_PER + 8'h01: per_wr_q <= {wdat, latch_q};
        `RTCS_IDX_CMP + 8'h01: cmp_wr_q <= {wdat, latch_q};
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Shared byte latch for every 16-bit pair.
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= `RTCS_RST_BYTE;
    end else if (wr && (idx == `RTCS_IDX_LATCH)) begin
      latch_q <= wdat;
    end else if (wr && (pair != 2'h0) && !idx[0]) begin
      latch_q <= wdat;
    end else if (rd && (pair != 2'h0) && !idx[0]) begin
      case (pair)
        2'h1: latch_q <= cnt_q[15:8];
        2'h2: latch_q <= per_q[15:8];
        default: latch_q <= cmp_q[15:8];
      endcase
    end
  end

  // Set wins over a simultaneous write-one clear.
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= 2'h0;
      pflag_q <= 1'b0;
    end else begin
      flags_q[`RTCS_CMP_BIT] <= cmp_ev | (flags_q[`RTCS_CMP_BIT] &
        ~(wr && (idx == `RTCS_IDX_FLAGS) && wdat[`RTCS_CMP_BIT]));
      flags_q[`RTCS_WRAP_BIT] <= wrap_ev | (flags_q[`RTCS_WRAP_BIT] &
        ~(wr && (idx == `RTCS_IDX_FLAGS) && wdat[`RTCS_WRAP_BIT]));
      pflag_q <= pit_ev | (pflag_q & ~(wr && (idx == `RTCS_IDX_PFLAGS) && wdat[0]));
    end
  end

  // ========================================================================
  // Crossing into the RTC timing logic
  genvar g;
  generate
    for (g = 0; g < `RTCS_SLOTS; g = g + 1) begin : g_slot
      rtcs_sync_slot u_slot (
        .clk(I_CLK_SYS),
        .rst_n(rst_n),
        .i_load(load[g]),
        .i_rtc_edge(rtc_edge),
        .o_busy(busy[g]),
        .o_apply(apply[g])
      );
    end
  endgenerate

  reg [7:0] ctrl_eff_q;
  reg [7:0] pctrl_eff_q;

  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_eff_q <= `RTCS_RST_BYTE;
      pctrl_eff_q <= `RTCS_RST_BYTE;
      per_q <= `RTCS_RST_LIMIT;
      cmp_q <= `RTCS_RST_WORD;
    end else begin
      if (apply[0]) begin
        ctrl_eff_q <= ctrl_q;
      end
      if (apply[2]) begin
        per_q <= per_wr_q;
      end
      if (apply[3]) begin
        cmp_q <= cmp_wr_q;
      end
      if (apply[4]) begin
        pctrl_eff_q <= pctrl_q;
      end
    end
  end

  // ========================================================================
  // Counter and periodic timer
  wire rtc_en;
  wire pit_en;
  wire rtc_go;
  wire pit_go;
  wire tick;
  wire pit_rise;
  wire [15:0] cnt_next;

  assign rtc_en = ctrl_eff_q[`RTCS_EN_BIT];
  assign pit_en = pctrl_eff_q[`RTCS_EN_BIT];
  // Standby stops the counter unless run_in_standby is set; idle never does.
  assign rtc_go = rtc_en & ~(I_SLEEP_STANDBY & ~ctrl_eff_q[`RTCS_CTRL_STBY]) &
    ~(I_DEBUG_HALT & ~dbg_q);
  // Sleep never gates the periodic timer, only a debug halt can.
  assign pit_go = pit_en & ~(I_DEBUG_HALT & ~pdbg_q);

  rtcs_prescaler u_presc (
    .clk(I_CLK_SYS),
    .rst_n(rst_n),
    .i_rtc_edge(rtc_edge),
    .i_run(rtc_en | pit_en),
    .i_div(ctrl_eff_q[`RTCS_DIV_MSB:`RTCS_DIV_LSB]),
    .i_period(pctrl_eff_q[6:3]),
    .o_tick(tick),
    .o_pit_rise(pit_rise)
  );

  assign cnt_next = (cnt_q == per_q) ? 16'h0000 : cnt_q + 16'h0001;
  assign wrap_ev = tick & rtc_go & (cnt_q == per_q);
  assign cmp_ev = tick & rtc_go & (cnt_next == cmp_q);
  assign pit_ev = pit_rise & pit_go;

  // A pending count write overrides a tick in the same cycle.
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `RTCS_RST_WORD;
    end else if (apply[1]) begin
      cnt_q <= cnt_wr_q;
    end else if (tick && rtc_go) begin
      cnt_q <= cnt_next;
    end
  end

  // ========================================================================
  // Read path
  reg [7:0] rd_mux;
  reg [31:0] prdata_q;

  always @* begin
    case (idx)
      `RTCS_IDX_CTRL: rd_mux = ctrl_q;
      `RTCS_IDX_STATUS: rd_mux = {4'h0, busy[3:0]};
      `RTCS_IDX_INTEN: rd_mux = {6'h00, inten_q};
      `RTCS_IDX_FLAGS: rd_mux = {6'h00, flags_q};
      `RTCS_IDX_LATCH: rd_mux = latch_q;
      `RTCS_IDX_DBG: rd_mux = {7'h00, dbg_q};
      `RTCS_IDX_SRCSEL: rd_mux = {6'h00, src_sel_q};
      `RTCS_IDX_CNT: rd_mux = cnt_q[7:0];
      `RTCS_IDX_PER: rd_mux = per_q[7:0];
      `RTCS_IDX_CMP: rd_mux = cmp_q[7:0];
      `RTCS_IDX_CNT + 8'h01,
      `RTCS_IDX_PER + 8'h01,
      `RTCS_IDX_CMP + 8'h01: rd_mux = latch_q;
      `RTCS_IDX_PCTRL: rd_mux = pctrl_q;
      `RTCS_IDX_PSTATUS: rd_mux = {7'h00, busy[4]};
      `RTCS_IDX_PINTEN: rd_mux = {7'h00, pinten_q};
      `RTCS_IDX_PFLAGS: rd_mux = {7'h00, pflag_q};
      `RTCS_IDX_PDBG: rd_mux = {7'h00, pdbg_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle and held through the access.
  always @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_q <= {24'h00_0000, rd_mux};
    end
  end
  assign O_PRDATA = prdata_q;

  // ========================================================================
  // Interrupt
  assign O_IRQ = |(flags_q & inten_q) | (pflag_q & pinten_q);

endmodule // rtcs_top

`default_nettype wire

// ===== tb/rtcs_top_chk.sv
// Purpose: Port-level checks for the real-time counter block.
// Assumes: Register index is PADDR[7:2]; read data loads at the setup edge.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module rtcs_top_chk (
  input wire I_CLK_SYS,        // Bus clock
  input wire I_NRST,           // Reset, active low
  input wire I_PSEL,           // APB select
  input wire I_PENABLE,        // APB enable
  input wire I_PWRITE,         // APB direction
  input wire [7:0] I_PADDR,    // APB byte address
  input wire [31:0] I_PWDATA,  // APB write data
  input wire [3:0] I_PSTRB,    // APB byte strobes
  input wire [31:0] O_PRDATA,  // APB read data
  input wire O_PREADY,         // APB ready
  input wire O_PSLVERR,        // APB error
  input wire O_IRQ             // Interrupt request
);
  // ==========================================================================
  // Decode
  wire [5:0] idx;
  wire rd_setup;
  wire wr_acc;
  wire unmapped;
  assign idx = I_PADDR[7:2];
  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
  assign unmapped = (idx == 6'h06) || (idx == 6'h0e) || (idx == 6'h0f) || (idx == 6'h14)
    || (idx > 6'h15);
  default clocking dc @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_NRST);

  // ==========================================================================
  // Properties
  status_bits_a: assert property (rd_setup && idx == 6'h01 |=> O_PRDATA[31:4] == 28'h0)
    else $error("status read shows bits beyond the pending flags");
  pstatus_bits_a: assert property (rd_setup && idx == 6'h11 |=> O_PRDATA[31:1] == 31'h0)
    else $error("periodic status read shows bits beyond its flag");
  flag_bits_a: assert property (rd_setup && idx == 6'h03 |=> O_PRDATA[31:2] == 30'h0)
    else $error("flag read shows bits beyond match and wrap");
  ctrl_bits_a: assert property (rd_setup && idx == 6'h00 |=> O_PRDATA[31:8] == 24'h0)
    else $error("control read shows bits above the byte");
  latch_back_a: assert property (wr_acc && I_PSTRB[0] && idx == 6'h04 ##1
    rd_setup && idx == 6'h04 |=> O_PRDATA[7:0] == $past(I_PWDATA[7:0], 2))
    else $error("byte latch does not return the written value");
  irq_fall_a: assert property ($fell(O_IRQ) |-> $past(wr_acc))
    else $error("interrupt dropped without a register write");
  reset_quiet_a: assert property ($rose(I_NRST) |-> !O_IRQ && O_PRDATA == 32'h0)
    else $error("outputs not quiet on leaving reset");
  unmapped_a: assert property (rd_setup && unmapped |=> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped read not refused");
endmodule // rtcs_top_chk

bind rtcs_top rtcs_top_chk i_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ)
);
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the real-time counter block.
// Assumes: RTC sources come from a free counter, far slower than the bus clock.
// Notes: Timing windows leave margin for the sampling of the slow sources.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic stby = 1'b0;
  logic osc32k = 1'b0;
  logic osc1k = 1'b0;
  logic ext = 1'b0;
  logic [7:0] cnt = 8'h00;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'd89;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic err_q[$];
  logic [5:0] um [5] = '{6'h06, 6'h0e, 6'h0f, 6'h14, 6'h3f};

  rtcs_top i_dut (
    .I_CLK_SYS(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hf), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_OSC32K(osc32k), .I_OSC1K(osc1k), .I_EXTCLK(ext),
    .I_SLEEP_STANDBY(stby), .I_DEBUG_HALT(1'b0), .O_IRQ(irq)
  );

  // ==========================================================================
  // Clocks
  always #2.5 clk = ~clk;
  // Each source is high and low for several bus cycles, as the sampler needs.
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    osc32k <= cnt[3];
    osc1k <= cnt[5];
    ext <= cnt[2];
  end

  // ==========================================================================
  // Tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic fail(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [5:0] ix, input logic [7:0] d,
                      input logic [7:0] ed, input logic [7:0] em, input logic ee);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    exp_q.push_back({24'h0, ed & em});
    msk_q.push_back(w ? 32'h0 : {24'hffffff, em});
    err_q.push_back(ee);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    penable <= 1'b0;
    if (n >= 50) begin
      fail("no ready");
      test_done;
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    xfer(1'b1, ix, d, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic rdm(input logic [5:0] ix, input logic [7:0] e, input logic [7:0] m);
    xfer(1'b0, ix, 8'h00, e, m, 1'b0);
  endtask
  task automatic rd(input logic [5:0] ix, input logic [7:0] e);
    rdm(ix, e, 8'hff);
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic chk_irq(input logic e);
    comparisons++;
    if (irq !== e) fail("interrupt level wrong");
  endtask
  task automatic align;
    for (int i = 0; i < 16 && cnt[3:0] !== 4'h9; i++) @(posedge clk);
    if (cnt[3:0] !== 4'h9) begin
      fail("no alignment with the source clock");
      test_done;
    end
  endtask

  // ==========================================================================
  // Result watcher
  always @(negedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) fail("result without note");
      else begin
        comparisons++;
        if ((prdata & msk_q[0]) !== exp_q[0] || pslverr !== err_q[0]) fail("read or error differs");
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
        void'(err_q.pop_front());
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail("run too long");
    test_done;
  end

  // ==========================================================================
  // Sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++) rd(6'(i), 8'h00);
    rd(6'h0a, 8'hff);
    rd(6'h0b, 8'hff);
    for (int i = 0; i < 5; i++) xfer(1'b0, um[i], 8'h00, 8'h00, 8'hff, 1'b1);
    xfer(1'b1, 6'h0e, 8'h5a, 8'h00, 8'h00, 1'b1);
    wr(6'h01, 8'hff);
    rd(6'h01, 8'h00);
    seed = xs(seed);
    wr(6'h04, seed[7:0]);
    rd(6'h04, seed[7:0]);
    wr(6'h08, 8'h34);
    wr(6'h09, 8'h12);
    rdm(6'h01, 8'h02, 8'h02);
    idle(60);
    rd(6'h01, 8'h00);
    rd(6'h08, 8'h34);
    rd(6'h09, 8'h12);
    wr(6'h0a, 8'h04);
    wr(6'h0b, 8'h00);
    wr(6'h0c, 8'h03);
    wr(6'h0d, 8'h00);
    rdm(6'h01, 8'h0c, 8'h0c);
    wr(6'h02, 8'h03);
    wr(6'h08, 8'h00);
    wr(6'h09, 8'h00);
    idle(60);
    rd(6'h01, 8'h00);
    align;
    wr(6'h00, 8'h11);
    rdm(6'h01, 8'h01, 8'h01);
    idle(8);
    rdm(6'h01, 8'h01, 8'h01);
    idle(26);
    rd(6'h01, 8'h00);
    idle(100);
    rd(6'h03, 8'h00);
    idle(100);
    rd(6'h03, 8'h02);
    chk_irq(1'b1);
    idle(120);
    rd(6'h03, 8'h03);
    wr(6'h02, 8'h02);
    wr(6'h03, 8'h02);
    rd(6'h03, 8'h01);
    chk_irq(1'b0);
    wr(6'h03, 8'h03);
    stby <= 1'b1;
    idle(700);
    rd(6'h03, 8'h00);
    wr(6'h00, 8'h91);
    idle(700);
    rd(6'h03, 8'h03);
    wr(6'h00, 8'h00);
    wr(6'h12, 8'h01);
    wr(6'h10, 8'h09);
    rd(6'h11, 8'h01);
    idle(60);
    wr(6'h03, 8'h03);
    wr(6'h13, 8'h01);
    idle(100);
    rd(6'h13, 8'h01);
    chk_irq(1'b1);
    wr(6'h10, 8'h01);
    idle(60);
    wr(6'h13, 8'h01);
    idle(200);
    rd(6'h13, 8'h00);
    chk_irq(1'b0);
    wr(6'h10, 8'h09);
    for (int s = 0; s < 4; s++) begin
      wr(6'h07, 8'(s));
      idle(80);
      wr(6'h13, 8'h01);
      idle(300);
      rd(6'h13, (s == 2) ? 8'h00 : 8'h01);
    end
    psel <= 1'b0;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(6'h00, 8'h00);
    rd(6'h0a, 8'hff);
    chk_irq(1'b0);
    idle(2);
    test_done;
  end
endmodule // tb
`default_nettype wire
